// >>> design/ulc_line_ctrl.sv
// serial line control, error flags and register slave
`timescale 1ns/1ps
`default_nettype none
module ulc_line_ctrl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial line
  input wire logic rx_in,
  output logic tx_out,
  input wire logic cts_n,
  output logic rts_n,
  output logic transmit_driver_enable,
  // protocol engine events
  input wire logic rate_gen_overflow,
  input wire logic dali_start_overflow,
  input wire logic lin_checksum_mismatch,
  output logic lin_checksum_include_pid
);
  typedef enum {TX_IDLE, TX_BREAK, TX_MARK, TX_START, TX_DATA, TX_STOP} ulc_tx_st_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_STOP2, RX_HALT} ulc_rx_st_t;

  // bus and register state
  logic [7:0] addr_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [7:0] line_control_two_q;
  logic [3:0] mode_q;
  logic break_flag_timing_q;
  logic break_send_request_q;
  logic [3:0] stk_q;
  logic [3:0] stk_d;
  logic [7:0] csum_q;
  logic [8:0] txh_q;
  logic txh_v_q;
  logic xoff_q;
  // transmit state
  ulc_tx_st_t tx_st_q;
  ulc_tx_st_t tx_st_d;
  logic [3:0] tx_div_q;
  logic [4:0] tx_cnt_q;
  logic [4:0] tx_cnt_d;
  logic [3:0] tx_bit_q;
  logic [3:0] tx_bit_d;
  logic [8:0] tx_sh_q;
  logic [8:0] tx_sh_d;
  logic tx_lvl_q;
  logic tx_lvl_d;
  logic tx_take;
  logic brk_done;
  logic tx_out_q;
  logic tx_de_q;
  logic rts_n_q;
  logic pid_q;
  // receive state
  ulc_rx_st_t rx_st_q;
  ulc_rx_st_t rx_st_d;
  logic [3:0] rx_div_q;
  logic [4:0] rx_cnt_q;
  logic [4:0] rx_cnt_d;
  logic [3:0] rx_bit_q;
  logic [3:0] rx_bit_d;
  logic [8:0] rx_sh_q;
  logic [8:0] rx_sh_d;
  logic rx_fe_q;
  logic rx_fe_d;
  logic rx_done;
  logic r_prev_q;
  logic [7:0] brk_cnt_q;
  // queue
  logic [ulc_pkg::FIFO_W-1:0] head;
  logic q_full;
  logic q_empty;

  // bus decode
  wire acc = hsel && htrans[1] && hready;
  wire [7:0] wd = hwdata[7:0];
  wire wr_lc2 = wr_pend_q && (addr_q == ulc_pkg::ADDR_LC2);
  wire wr_err = wr_pend_q && (addr_q == ulc_pkg::ADDR_ERR);
  wire wr_ctrl = wr_pend_q && (addr_q == ulc_pkg::ADDR_CTRL);
  wire wr_txb = wr_pend_q && (addr_q == ulc_pkg::ADDR_TXB);
  wire wr_csum = wr_pend_q && (addr_q == ulc_pkg::ADDR_CSUM);
  wire rd_rxb = rd_pend_q && (addr_q == ulc_pkg::ADDR_RXB);

  // control fields
  wire run_on_overflow = line_control_two_q[ulc_pkg::LC2_RUN_ON_OVERFLOW];
  wire rx_inv = line_control_two_q[ulc_pkg::LC2_RXINV];
  wire [1:0] stop_bit_select = line_control_two_q[ulc_pkg::LC2_STP +: 2];
  wire csel = line_control_two_q[ulc_pkg::LC2_CSEL];
  wire tx_inv = line_control_two_q[ulc_pkg::LC2_TXINV];
  wire [1:0] flow = line_control_two_q[ulc_pkg::LC2_FLOW +: 2];

  // mode classes; upper half of the mode space is the protocol set
  wire proto = mode_q[3];
  wire is_lin = (mode_q == ulc_pkg::MODE_LIN_CLIENT) || (mode_q == ulc_pkg::MODE_LIN_HOST);
  wire is_dali = (mode_q == ulc_pkg::MODE_DALI_DEV) || (mode_q == ulc_pkg::MODE_DALI_GEAR);
  wire is_odd = (mode_q == ulc_pkg::MODE_ODD);
  wire is_even = (mode_q == ulc_pkg::MODE_EVEN);
  wire is_addr = (mode_q == ulc_pkg::MODE_ADDR);
  wire mark_bit = is_addr || (mode_q == ulc_pkg::MODE_DALI_DEV);
  wire seven = (mode_q == ulc_pkg::MODE_7BIT);
  wire nine = is_odd || is_even || mark_bit;
  wire [3:0] nbits = nine ? 4'h9 : (seven ? 4'h7 : 4'h8);

  // stop length in half bits
  wire [4:0] stop_halves = (stop_bit_select == ulc_pkg::STP_ONE) ? 5'h2 :
    (stop_bit_select == ulc_pkg::STP_ONE_HALF) ? 5'h3 : 5'h4;

  // flow gating of the transmitter
  wire flow_ok = (flow == ulc_pkg::FLOW_XON) ? !xoff_q :
    (flow == ulc_pkg::FLOW_HW) ? !cts_n : 1'b1;

  // frame bits for the held byte: ninth bit is parity or address mark
  wire par_bit = is_even ? ^txh_q[7:0] : ~^txh_q[7:0];
  wire ninth_tx = (is_odd || is_even) ? par_bit : txh_q[8];
  wire [8:0] tx_frame = {ninth_tx, txh_q[7:0]};

  // receive line after polarity
  wire r = rx_in ^ rx_inv;
  wire tx_tick = (tx_div_q == ulc_pkg::HALF_LAST);
  wire rx_tick = (rx_div_q == ulc_pkg::HALF_LAST);

  // transmit sequencing in half-bit units
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    tx_lvl_d = tx_lvl_q;
    tx_take = 1'b0;
    brk_done = 1'b0;
    case (tx_st_q)
      TX_IDLE: begin
        tx_lvl_d = 1'b1;
        if (txh_v_q && flow_ok) begin
          tx_take = 1'b1;
          tx_sh_d = tx_frame;
          tx_lvl_d = 1'b0;
          if (break_send_request_q) begin
            tx_st_d = TX_BREAK;
            tx_cnt_d = ulc_pkg::TX_BRK_HALVES;
          end else begin
            tx_st_d = TX_START;
            tx_cnt_d = 5'h2;
          end
        end
      end
      default: begin
        if (tx_tick) begin
          if (tx_cnt_q != 5'h1) begin
            tx_cnt_d = tx_cnt_q - 5'h1;
          end else begin
            tx_cnt_d = 5'h2;
            case (tx_st_q)
              TX_BREAK: begin
                tx_st_d = TX_MARK;
                tx_lvl_d = 1'b1;
                brk_done = 1'b1;
              end
              TX_MARK: begin
                tx_st_d = TX_START;
                tx_lvl_d = 1'b0;
              end
              TX_START, TX_DATA: begin
                if (tx_st_q == TX_DATA && tx_bit_q == nbits - 4'h1) begin
                  tx_st_d = TX_STOP;
                  tx_lvl_d = 1'b1;
                  tx_cnt_d = stop_halves;
                end else begin
                  tx_st_d = TX_DATA;
                  tx_lvl_d = tx_sh_q[0];
                  tx_sh_d = {1'b0, tx_sh_q[8:1]};
                  tx_bit_d = (tx_st_q == TX_START) ? 4'h0 : tx_bit_q + 4'h1;
                end
              end
              default: tx_st_d = TX_IDLE;
            endcase
          end
        end
      end
    endcase
  end

  // receive sequencing, sampling mid-bit
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_fe_d = rx_fe_q;
    rx_done = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        if (r_prev_q && !r) begin
          rx_st_d = RX_START;
          rx_cnt_d = 5'h1;
        end
      end
      RX_HALT: begin
        if (!stk_q[0]) begin
          rx_st_d = RX_IDLE;
        end
      end
      default: begin
        if (rx_tick) begin
          if (rx_cnt_q != 5'h1) begin
            rx_cnt_d = rx_cnt_q - 5'h1;
          end else begin
            rx_cnt_d = 5'h2;
            case (rx_st_q)
              RX_START: begin
                rx_st_d = r ? RX_IDLE : RX_DATA;
                rx_bit_d = 4'h0;
              end
              RX_DATA: begin
                rx_sh_d = {r, rx_sh_q[8:1]};
                rx_bit_d = rx_bit_q + 4'h1;
                if (rx_bit_q == nbits - 4'h1) begin
                  rx_st_d = RX_STOP;
                end
              end
              RX_STOP: begin
                rx_fe_d = !r;
                if (stop_bit_select == ulc_pkg::STP_TWO_BOTH) begin
                  rx_st_d = RX_STOP2;
                end else begin
                  rx_done = 1'b1;
                  rx_st_d = RX_IDLE;
                end
              end
              default: begin
                rx_fe_d = rx_fe_q || !r;
                rx_done = 1'b1;
                rx_st_d = RX_IDLE;
              end
            endcase
            if (rx_done && q_full && !run_on_overflow) begin
              rx_st_d = RX_HALT;
            end
          end
        end
      end
    endcase
  end

  // received character, ninth bit and marks
  wire [8:0] rx_word = seven ? {2'h0, rx_sh_d[8:2]} :
    (nine ? rx_sh_d : {1'b0, rx_sh_d[8:1]});
  wire par_bad = (is_even && ^rx_word) || (is_odd && !(^rx_word));
  wire perr = mark_bit ? rx_word[8] : par_bad;
  wire push = rx_done && !q_full;
  wire ovf_set = rx_done && q_full;

  // break detection on the receive line
  wire brk_hit = !r && (brk_cnt_q == ulc_pkg::RX_BRK_LAST - 8'h01);
  wire brk_rise = r && (brk_cnt_q == ulc_pkg::RX_BRK_LAST);
  wire brk_set = break_flag_timing_q ? brk_hit : brk_rise;

  // hardware events into the sticky flags: overflow, break, checksum, rate (DALI start overflow in DALI modes)
  wire abd_set = is_dali ? dali_start_overflow : rate_gen_overflow;
  wire cerr_set = is_lin && lin_checksum_mismatch;
  wire [3:0] stk_set = {abd_set, cerr_set, brk_set, ovf_set};
  always_comb begin
    stk_d = wr_err ? {wd[ulc_pkg::ERR_ABD], wd[ulc_pkg::ERR_CSUM],
      wd[ulc_pkg::ERR_BRK], wd[ulc_pkg::ERR_OVF]} : stk_q;
    stk_d = stk_d | stk_set;
  end

  // checksum accumulation of both directions outside LIN
  wire acc_on = csel && !is_lin;
  wire [7:0] tx_add = (acc_on && tx_take) ? txh_q[7:0] : 8'h00;
  wire [7:0] rx_add = (acc_on && push) ? rx_word[7:0] : 8'h00;

  // read view of the flags; head marks only when something is queued
  wire shifter_empty = (tx_st_q == TX_IDLE);
  wire [7:0] err_view = {shifter_empty, head[9] && !q_empty, stk_q[3], stk_q[2],
    head[10] && !q_empty, stk_q[1], stk_q[0], 1'b0};
  wire [31:0] rdata =
    (addr_q == ulc_pkg::ADDR_LC2) ? {24'h000000, line_control_two_q} :
    (addr_q == ulc_pkg::ADDR_ERR) ? {24'h000000, err_view} :
    (addr_q == ulc_pkg::ADDR_CTRL) ? {26'h0000000, break_send_request_q,
      break_flag_timing_q, mode_q} :
    (addr_q == ulc_pkg::ADDR_RXB) ? {q_empty, 20'h00000, head} :
    (addr_q == ulc_pkg::ADDR_CSUM) ? {24'h000000, csum_q} : 32'h00000000;

  // bus phases: writes land with no wait, reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= acc && hwrite && (hsize == 3'h2);
      rd_pend_q <= acc && !hwrite;
      hreadyout_q <= !(acc && !hwrite);
      if (acc) begin
        addr_q <= haddr;
      end
      if (rd_pend_q) begin
        hrdata_q <= rdata;
      end
    end
  end

  // software-written control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_control_two_q <= ulc_pkg::LC2_RST;
      {break_send_request_q, break_flag_timing_q, mode_q} <= ulc_pkg::CTRL_RST;
    end else begin
      if (wr_lc2) begin
        line_control_two_q <= wd;
      end
      if (wr_ctrl) begin
        mode_q <= wd[ulc_pkg::CTRL_MODE +: 4];
        break_flag_timing_q <= wd[ulc_pkg::CTRL_BRKTIM];
      end
      if (brk_done) begin
        break_send_request_q <= 1'b0;
      end else if (wr_ctrl && !proto) begin
        break_send_request_q <= wd[ulc_pkg::CTRL_BREAK_SEND_REQUEST];
      end
    end
  end

  // flags, holding byte, checksum and flow state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stk_q <= 4'h0;
      csum_q <= 8'h00;
      txh_q <= 9'h000;
      txh_v_q <= 1'b0;
      xoff_q <= 1'b0;
    end else begin
      stk_q <= stk_d;
      csum_q <= (wr_csum ? wd : csum_q) + tx_add + rx_add;
      if (wr_txb) begin
        txh_q <= hwdata[8:0];
      end
      txh_v_q <= wr_txb || (txh_v_q && !tx_take);
      if (push && flow == ulc_pkg::FLOW_XON && rx_word[7:0] == ulc_pkg::XOFF_CHAR) begin
        xoff_q <= 1'b1;
      end else if (push && rx_word[7:0] == ulc_pkg::XON_CHAR) begin
        xoff_q <= 1'b0;
      end
    end
  end

  // transmit registers and line pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_q <= TX_IDLE;
      tx_div_q <= 4'h0;
      tx_cnt_q <= 5'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h000;
      tx_lvl_q <= 1'b1;
      tx_out_q <= 1'b1;
      tx_de_q <= 1'b0;
      rts_n_q <= 1'b1;
      pid_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_div_q <= (tx_st_q == TX_IDLE || tx_tick) ? 4'h0 : tx_div_q + 4'h1;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      tx_lvl_q <= tx_lvl_d;
      tx_out_q <= tx_lvl_d ^ tx_inv;
      tx_de_q <= (flow == ulc_pkg::FLOW_HW) && (tx_st_d != TX_IDLE);
      rts_n_q <= !((flow == ulc_pkg::FLOW_HW) && !q_full);
      pid_q <= is_lin && csel;
    end
  end

  // receive registers; halt clears the break counter too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q <= RX_IDLE;
      rx_div_q <= 4'h0;
      rx_cnt_q <= 5'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_fe_q <= 1'b0;
      r_prev_q <= 1'b1;
      brk_cnt_q <= 8'h00;
    end else begin
      rx_st_q <= rx_st_d;
      rx_div_q <= (rx_st_q == RX_IDLE || rx_tick) ? 4'h0 : rx_div_q + 4'h1;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_fe_q <= rx_fe_d;
      r_prev_q <= r;
      if (r || rx_st_q == RX_HALT) begin
        brk_cnt_q <= 8'h00;
      end else if (brk_cnt_q != ulc_pkg::RX_BRK_LAST) begin
        brk_cnt_q <= brk_cnt_q + 8'h01;
      end
    end
  end

  // receive queue, popped by reading the receive data register
  ulc_rx_fifo u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(push),
    .push_data({rx_fe_d, perr, rx_word}),
    .pop(rd_rxb),
    .head(head),
    .full(q_full),
    .empty(q_empty)
  );

  // pins straight from flip-flops
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign tx_out = tx_out_q;
  assign transmit_driver_enable = tx_de_q;
  assign rts_n = rts_n_q;
  assign lin_checksum_include_pid = pid_q;
endmodule // ulc_line_ctrl
`default_nettype wire

// >>> design/ulc_pkg.sv
// shared constants for the line-control and error-flag block
package ulc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_LC2 = 8'h00;
  localparam logic [7:0] ADDR_ERR = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_TXB = 8'h0C;
  localparam logic [7:0] ADDR_RXB = 8'h10;
  localparam logic [7:0] ADDR_CSUM = 8'h14;
  // line_control_two fields
  localparam int LC2_RUN_ON_OVERFLOW = 7;
  localparam int LC2_RXINV = 6;
  localparam int LC2_STP = 4;
  localparam int LC2_CSEL = 3;
  localparam int LC2_TXINV = 2;
  localparam int LC2_FLOW = 0;
  localparam logic [7:0] LC2_RST = 8'h00;
  // error_flag_status fields
  localparam int ERR_TXMT = 7;
  localparam int ERR_PAR = 6;
  localparam int ERR_ABD = 5;
  localparam int ERR_CSUM = 4;
  localparam int ERR_FRM = 3;
  localparam int ERR_BRK = 2;
  localparam int ERR_OVF = 1;
  localparam logic [7:0] ERR_RST = 8'h80;
  // mode/control register fields
  localparam int CTRL_MODE = 0;
  localparam int CTRL_BRKTIM = 4;
  localparam int CTRL_BREAK_SEND_REQUEST = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // receive data register status bit
  localparam int RXB_EMPTY = 31;
  // operating modes
  localparam logic [3:0] MODE_8BIT = 4'h0;
  localparam logic [3:0] MODE_7BIT = 4'h1;
  localparam logic [3:0] MODE_ODD = 4'h2;
  localparam logic [3:0] MODE_EVEN = 4'h3;
  localparam logic [3:0] MODE_ADDR = 4'h4;
  localparam logic [3:0] MODE_DALI_DEV = 4'h8;
  localparam logic [3:0] MODE_DALI_GEAR = 4'h9;
  localparam logic [3:0] MODE_LIN_CLIENT = 4'hB;
  localparam logic [3:0] MODE_LIN_HOST = 4'hC;
  // stop select and flow codes
  localparam logic [1:0] STP_ONE = 2'h0;
  localparam logic [1:0] STP_ONE_HALF = 2'h1;
  localparam logic [1:0] STP_TWO_BOTH = 2'h2;
  localparam logic [1:0] FLOW_XON = 2'h1;
  localparam logic [1:0] FLOW_HW = 2'h2;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int BAUD_BPS = 1250000;
  localparam int HALF_CYC = CLK_HZ / (2 * BAUD_BPS);
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
  localparam int TX_BRK_BITS = 13;
  localparam logic [4:0] TX_BRK_HALVES = 5'(2 * TX_BRK_BITS);
  localparam int RX_BRK_BITS = 11;
  localparam logic [7:0] RX_BRK_LAST = 8'(RX_BRK_BITS * 2 * HALF_CYC);
  // receive queue
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = 11;
endpackage

// >>> design/ulc_rx_fifo.sv
// receive queue holding data with per-entry error marks
`timescale 1ns/1ps
`default_nettype none
module ulc_rx_fifo (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // write side
  input wire logic push,
  input wire logic [ulc_pkg::FIFO_W-1:0] push_data,
  // read side
  input wire logic pop,
  output logic [ulc_pkg::FIFO_W-1:0] head,
  output logic full,
  output logic empty
);
  logic [ulc_pkg::FIFO_W-1:0] mem_q [ulc_pkg::FIFO_DEPTH];
  logic [1:0] wp_q;
  logic [1:0] rp_q;
  logic [2:0] cnt_q;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  // status from the fill count
  assign full = (cnt_q == 3'(ulc_pkg::FIFO_DEPTH));
  assign empty = (cnt_q == 3'h0);
  assign head = mem_q[rp_q];

  // storage has no reset; head shows mem_q[rp_q] even when the fill count is zero
  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem_q[wp_q] <= push_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
    end else begin
      wp_q <= wp_q + 2'(do_push);
      rp_q <= rp_q + 2'(do_pop);
      cnt_q <= cnt_q + 3'(do_push) - 3'(do_pop);
    end
  end
endmodule // ulc_rx_fifo
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the line-control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_out, rts_n, rx_in, cts_n;
  logic rate_gen_overflow, dali_start_overflow, lin_checksum_mismatch;
  logic transmit_driver_enable, lin_checksum_include_pid;
  logic [7:0] haddr, got;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, v;
  wire logic hready = hreadyout;
  int gap, d, fails = 0, checks = 0, cyc = 0;
  // mode, event {rate, dali, lin} and flag byte after it
  logic [3:0] em [6] = '{4'h0, 4'hB, 4'h0, 4'h8, 4'h8, 4'h0};
  logic [2:0] ev [6] = '{3'h1, 3'h1, 3'h4, 3'h4, 3'h2, 3'h2};
  logic [7:0] ee [6] = '{8'h80, 8'h90, 8'hA0, 8'h80, 8'hA0, 8'h80};
  // ninth-bit frames that raise the mark in modes 2, 3, 4, 8
  logic [8:0] pw [4] = '{9'h101, 9'h001, 9'h1AA, 9'h100};
  ulc_line_ctrl ulc_line_ctrl_inst (.*);
  ulc_node ulc_node_inst (.hclk(hclk), .tx_out(tx_out), .rx_in(rx_in), .cts_n(cts_n),
    .got(got), .gap(gap));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // a hang counts as a mismatch
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // single-word bus write; address held until hready
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= dt;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dt);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    dt = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] r;
    rd(a, r);
    chk(n, r, e);
  endtask
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} <= '0;
    {rate_gen_overflow, dali_start_overflow, lin_checksum_mismatch} <= 3'h0;
    hsize <= 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(ulc_pkg::ADDR_LC2, 32'h0, "lc2_rst");
    rc(ulc_pkg::ADDR_ERR, 32'h80, "err_rst");
    rc(8'h1C, 32'h0, "unmapped");
    wr(ulc_pkg::ADDR_LC2, 32'h04);
    repeat (12) @(posedge hclk);
    chk("tx_idle_inv", tx_out, 1'b0);
    wr(ulc_pkg::ADDR_LC2, 32'h08);
    // the node is still sampling the low idle it took for a start bit
    repeat (150) @(posedge hclk);
    $display("reset and polarity done");
    // event inputs against modes, flags cleared by software each time
    for (int k = 0; k < 6; k++) begin
      wr(ulc_pkg::ADDR_CTRL, {28'h0, em[k]});
      {rate_gen_overflow, dali_start_overflow, lin_checksum_mismatch} <= ev[k];
      @(posedge hclk);
      {rate_gen_overflow, dali_start_overflow, lin_checksum_mismatch} <= 3'h0;
      rc(ulc_pkg::ADDR_ERR, {24'h0, ee[k]}, "event");
      wr(ulc_pkg::ADDR_ERR, 32'h0);
    end
    wr(ulc_pkg::ADDR_CTRL, 32'h0B);
    wr(ulc_pkg::ADDR_CTRL, 32'h2B);
    repeat (2) @(posedge hclk);
    chk("pid", lin_checksum_include_pid, 1'b1);
    rc(ulc_pkg::ADDR_CTRL, 32'h0B, "break_send_request_ro");
    wr(ulc_pkg::ADDR_ERR, 32'h36);
    rc(ulc_pkg::ADDR_ERR, 32'hB6, "sw_set");
    wr(ulc_pkg::ADDR_ERR, 32'h0);
    wr(ulc_pkg::ADDR_CTRL, 32'h0);
    wr(ulc_pkg::ADDR_CSUM, 32'h0);
    $display("events done");
    // two frames back to back at each stop setting, hardware flow on
    for (int s = 0; s < 4; s++) begin
      wr(ulc_pkg::ADDR_LC2, 32'h0A | (s << 4));
      wr(ulc_pkg::ADDR_TXB, 32'hC0);
      repeat (40) @(posedge hclk);
      wr(ulc_pkg::ADDR_TXB, 32'hC0);
      chk("drv_en", transmit_driver_enable, 1'b1);
      chk("rts", rts_n, 1'b0);
      rd(ulc_pkg::ADDR_ERR, v);
      chk("busy", v[7], 1'b0);
      repeat (400) @(posedge hclk);
      d = gap - 144 - (s == 0 ? 16 : s == 1 ? 24 : 32);
      chk("stop_len", d >= 0 && d < 4, 1'b1);
      chk("tx_byte", got, 8'hC0);
      if (s == 0) rc(ulc_pkg::ADDR_CSUM, 32'h80, "sum");
    end
    rc(ulc_pkg::ADDR_ERR, 32'h80, "empty");
    // break ahead of the written byte
    wr(ulc_pkg::ADDR_CTRL, 32'h20);
    wr(ulc_pkg::ADDR_TXB, 32'hC0);
    repeat (500) @(posedge hclk);
    d = gap - 224;
    chk("brk_gap", d >= 0 && d < 4, 1'b1);
    rc(ulc_pkg::ADDR_CTRL, 32'h0, "break_send_request_clr");
    wr(ulc_pkg::ADDR_LC2, 32'h0);
    $display("transmit done");
    // good frame, then framing error following the queue head
    ulc_node_inst.send(9'h3C, 8, 1'b1, 1'b0);
    rc(ulc_pkg::ADDR_RXB, 32'h3C, "rx");
    ulc_node_inst.send(9'h3C, 8, 1'b0, 1'b0);
    rc(ulc_pkg::ADDR_ERR, 32'h88, "frm");
    rc(ulc_pkg::ADDR_RXB, 32'h43C, "rx_frm");
    rc(ulc_pkg::ADDR_ERR, 32'h80, "frm_gone");
    for (int k = 0; k < 4; k++) begin
      wr(ulc_pkg::ADDR_CTRL, k < 3 ? 32'h2 + k : 32'h8);
      ulc_node_inst.send(pw[k], 9, 1'b1, 1'b0);
      rc(ulc_pkg::ADDR_ERR, 32'hC0, "mark");
      rd(ulc_pkg::ADDR_RXB, v);
    end
    wr(ulc_pkg::ADDR_CTRL, 32'h0);
    // overflow, halted or still running
    for (int r = 0; r < 2; r++) begin
      wr(ulc_pkg::ADDR_LC2, r << 7);
      for (int k = 0; k < 5; k++) ulc_node_inst.send(9'h5A, 8, 1'b1, 1'b0);
      rc(ulc_pkg::ADDR_ERR, 32'h82, "ovf");
      for (int k = 0; k < 4; k++) rd(ulc_pkg::ADDR_RXB, v);
      ulc_node_inst.send(9'h5A, 8, 1'b1, 1'b0);
      rd(ulc_pkg::ADDR_RXB, v);
      chk("run_on", v[31], !r);
      wr(ulc_pkg::ADDR_ERR, 32'h0);
    end
    $display("receive done");
    // break flag at the minimum time or at the rise
    for (int t = 1; t >= 0; t--) begin
      wr(ulc_pkg::ADDR_CTRL, t << 4);
      ulc_node_inst.line(1'b0);
      repeat (190) @(posedge hclk);
      rd(ulc_pkg::ADDR_ERR, v);
      chk("brk_low", v[2], t[0]);
      ulc_node_inst.line(1'b1);
      repeat (20) @(posedge hclk);
      rd(ulc_pkg::ADDR_ERR, v);
      chk("brk", v[2], 1'b1);
      wr(ulc_pkg::ADDR_ERR, 32'h0);
    end
    repeat (4) rd(ulc_pkg::ADDR_RXB, v);
    // inverted receive line idles low
    ulc_node_inst.line(1'b0);
    wr(ulc_pkg::ADDR_LC2, 32'h40);
    ulc_node_inst.send(9'h3C, 8, 1'b1, 1'b1);
    rc(ulc_pkg::ADDR_RXB, 32'h3C, "rx_inv");
    $display("break and polarity done");
    give_verdict;
  end
endmodule // tb
`default_nettype wire

// >>> verification/ulc_monitor.sv
// assertion checker on the line-control block ports
`timescale 1ns/1ps
`default_nettype none
module ulc_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // serial line
  input wire logic tx_out,
  input wire logic rts_n,
  input wire logic transmit_driver_enable,
  input wire logic lin_checksum_include_pid
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // address phase taken at this edge
  wire logic take = hsel && htrans[1] && hready;
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  write_fast_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(take) && !$past(hwrite))
    else $error("wait without a read");
  wait_once_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait longer than one cycle");
  rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  // a line level lasts half a bit at least; stop and break run longer
  tx_hold_a: assert property ($changed(tx_out) |=> $stable(tx_out) [*7])
    else $error("line bit too short");
  idle_out_a: assert property ($rose(hresetn) |-> tx_out && rts_n && !transmit_driver_enable)
    else $error("line not idle after reset");
  // main scenarios reached
  cover property (take && !hwrite);
  cover property (transmit_driver_enable);
  cover property (lin_checksum_include_pid);
endmodule // ulc_monitor
bind ulc_line_ctrl ulc_monitor ulc_monitor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .tx_out(tx_out), .rts_n(rts_n),
  .transmit_driver_enable(transmit_driver_enable),
  .lin_checksum_include_pid(lin_checksum_include_pid));
`default_nettype wire

// >>> verification/ulc_node.sv
// remote serial node on the far end of the line
`timescale 1ns/1ps
`default_nettype none
module ulc_node (
  // clock
  input wire logic hclk,
  // line
  input wire logic tx_out,
  output var logic rx_in,
  output var logic cts_n,
  // last byte heard and cycles between frame starts
  output var logic [7:0] got,
  output var int gap
);
  int cyc = 0;
  int last = 0;
  // idle line, always clear to send
  initial begin
    rx_in = 1'b1;
    cts_n = 1'b0;
    got = 8'h00;
    gap = 0;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  // idle, start, n bits lsb first, one stop of level stop_bit_select, idle
  task automatic send(input logic [8:0] w, input int n, input logic stop_bit_select, input logic inv);
    rx_in <= ~inv;
    repeat (16) @(posedge hclk);
    rx_in <= inv;
    repeat (16) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      rx_in <= w[i] ^ inv;
      repeat (16) @(posedge hclk);
    end
    rx_in <= stop_bit_select ^ inv;
    repeat (16) @(posedge hclk);
    rx_in <= ~inv;
    repeat (16) @(posedge hclk);
  endtask
  // hold the line at a level, for breaks
  task automatic line(input logic lv);
    rx_in <= lv;
  endtask
  // start edge timing, then mid-bit sampling of eight bits
  always begin
    @(negedge tx_out);
    gap = cyc - last;
    last = cyc;
    repeat (8) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge hclk);
      got[i] = tx_out;
    end
  end
endmodule // ulc_node
`default_nettype wire
